// ===== design/io_failsafe_pkg.sv
// Constants, register map and field layout of the six-channel I/O module control block.
// Assumes a 200 MHz system clock; the flash rates are derived from it here.
package io_failsafe_pkg;

  // Clock rate and indicator flash rates, the latter in millihertz.
  localparam longint CLK_HZ = 200000000;
  localparam longint SLOW_FLASH_MHZ = 1400;
  localparam longint FAST_FLASH_MHZ = 2800;
  localparam longint SLOW_HALF_CYCLES = (CLK_HZ * 1000) / (2 * SLOW_FLASH_MHZ);
  localparam longint FAST_HALF_CYCLES = (CLK_HZ * 1000) / (2 * FAST_FLASH_MHZ);

  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;

  // Register indices on the plain register port.
  localparam logic [3:0] REG_IN_ANALOG = 4'h0;
  localparam logic [3:0] REG_IN_DIGITAL = 4'h1;
  localparam logic [3:0] REG_IN_STATUS = 4'h2;
  localparam logic [3:0] REG_OUT_ANALOG = 4'h3;
  localparam logic [3:0] REG_OUT_RELAY = 4'h4;
  localparam logic [3:0] REG_OUT_SPARE = 4'h5;
  localparam logic [3:0] REG_LINK_CTRL = 4'h6;
  localparam logic [3:0] REG_IRQ_STATUS = 4'h7;
  localparam logic [3:0] REG_IRQ_ENABLE = 4'h8;
  localparam logic [3:0] REG_IRQ_CLEAR = 4'h9;

  // Link control fields.
  localparam int LC_STATE_LSB = 0;
  localparam int LC_FB_MODE = 2;
  localparam int LC_FB_OK = 3;
  localparam int LC_MISSING = 4;
  localparam int LC_CRITICAL = 5;
  localparam int LC_ADDR_ACK = 6;

  // Front switch positions.
  localparam int SW_AIN_RANGE = 0;
  localparam int SW_AOUT_HOLD = 1;
  localparam int SW_RELAY1_HOLD = 2;
  localparam int SW_RELAY2_HOLD = 3;

  // Interrupt status bits.
  localparam int IRQ_COMM_ERR = 0;
  localparam int IRQ_ADDR_CHG = 1;
  localparam int IRQ_CRITICAL = 2;
  localparam int IRQ_INPUT_CHG = 3;
  localparam int IRQ_W = 4;

  localparam logic [15:0] RESET_WORD = 16'h0000;
  localparam logic [3:0] RESET_IRQ = 4'h0;
  localparam logic [3:0] DIGIT_MAX = 4'h9;

  typedef enum logic [1:0] {
    LINK_NONE = 2'b00,
    LINK_CONFIG = 2'b01,
    LINK_CYCLIC = 2'b11
  } link_state_t;

endpackage : io_failsafe_pkg

// ===== design/io_failsafe_status.sv
// Control and status logic of a six-channel analog/digital I/O extension module.
// Assumes switches, thumbwheel and digital inputs are asynchronous pins and the
// analog input code comes from a converter on the same clock.
//
// Contract
// - Front switch changes take effect at once while running, no commit needed.
// - On communication error analog output goes to zero or holds, per switch.
// - On communication error each relay drops out or holds, per its switch.
// - Lost fieldbus in fieldbus-slave mode drives outputs to the switch-chosen safe state.
// - Bus indicator off without link, flashing while configuring, steady in cyclic exchange.
// - Error indicator flashes slowly at 1.4 Hz after address selector change.
// - Error indicator flashes at 2.8 Hz on missing partner or lost communication.
// - Error indicator off without error, steadily lit on critical internal error.
// - One indicator per digital input follows that input.
// - One indicator per relay output follows that output.
// - Address 01 to 99 valid, 00 default, tens with zero units invalid.
// - Process image is three input and three output 16-bit words.
//
// Design decisions made here: the register offsets and the plain strobed port.
`timescale 1ns/1ps
module io_failsafe_status #(
  parameter longint SLOW_HALF = io_failsafe_pkg::SLOW_HALF_CYCLES,
  parameter longint FAST_HALF = io_failsafe_pkg::FAST_HALF_CYCLES
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  output logic irq,
  input wire logic [3:0] front_switch,
  input wire logic [3:0] addr_tens,
  input wire logic [3:0] addr_units,
  input wire logic digital_in_first,
  input wire logic digital_in_second,
  input wire logic [15:0] analog_in_code,
  output logic [15:0] analog_out_code,
  output logic relay_out_first,
  output logic relay_out_second,
  output logic range_4_20,
  output logic supply_indicator,
  output logic bus_activity_indicator,
  output logic error_indicator,
  output logic [1:0] digital_in_indicator,
  output logic [1:0] relay_out_indicator
);

  logic [3:0] sw_m, sw_s;
  logic [3:0] tens_m, tens_s, units_m, units_s;
  logic [1:0] din_m, din_s, din_prev;
  logic [15:0] out_analog, out_relay, out_spare;
  io_failsafe_pkg::link_state_t link_state;
  logic fb_mode, fb_ok, missing, critical;
  logic addr_changed, addr_primed;
  logic [1:0] prime_sr;
  logic [7:0] addr_prev;
  logic [3:0] irq_status, irq_enable;
  logic comm_err, comm_err_d, critical_d;
  logic addr_valid;
  logic [3:0] events;
  logic [31:0] slow_cnt, fast_cnt;
  logic slow_ph, fast_ph;

  // Thumbwheel digits are BCD; a digit above nine can only come from a faulty wheel.
  function automatic logic addr_ok(input logic [3:0] t, input logic [3:0] u);
    addr_ok = (t <= io_failsafe_pkg::DIGIT_MAX) && (u <= io_failsafe_pkg::DIGIT_MAX)
      && (u != 4'h0);
  endfunction : addr_ok

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sw_m <= 4'h0;
      sw_s <= 4'h0;
      tens_m <= 4'h0;
      tens_s <= 4'h0;
      units_m <= 4'h0;
      units_s <= 4'h0;
      din_m <= 2'h0;
      din_s <= 2'h0;
    end else begin
      sw_m <= front_switch;
      sw_s <= sw_m;
      tens_m <= addr_tens;
      tens_s <= tens_m;
      units_m <= addr_units;
      units_s <= units_m;
      din_m <= {digital_in_second, digital_in_first};
      din_s <= din_m;
    end
  end

  assign addr_valid = addr_ok(tens_s, units_s);
  // A lost fieldbus counts only while the head works as a fieldbus slave.
  assign comm_err = (link_state == io_failsafe_pkg::LINK_NONE) || (fb_mode && !fb_ok);

  // Register writes.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      out_analog <= io_failsafe_pkg::RESET_WORD;
      out_relay <= io_failsafe_pkg::RESET_WORD;
      out_spare <= io_failsafe_pkg::RESET_WORD;
      link_state <= io_failsafe_pkg::LINK_NONE;
      fb_mode <= 1'b0;
      fb_ok <= 1'b0;
      missing <= 1'b0;
      critical <= 1'b0;
      irq_enable <= io_failsafe_pkg::RESET_IRQ;
    end else if (reg_wr) begin
      if (reg_addr == io_failsafe_pkg::REG_OUT_ANALOG) begin
        out_analog <= reg_wdata;
      end else if (reg_addr == io_failsafe_pkg::REG_OUT_RELAY) begin
        out_relay <= reg_wdata;
      end else if (reg_addr == io_failsafe_pkg::REG_OUT_SPARE) begin
        out_spare <= reg_wdata;
      end else if (reg_addr == io_failsafe_pkg::REG_LINK_CTRL) begin
        // An unused state code falls back to no link.
        case (reg_wdata[io_failsafe_pkg::LC_STATE_LSB +: 2])
          2'b01: link_state <= io_failsafe_pkg::LINK_CONFIG;
          2'b11: link_state <= io_failsafe_pkg::LINK_CYCLIC;
          default: link_state <= io_failsafe_pkg::LINK_NONE;
        endcase
        fb_mode <= reg_wdata[io_failsafe_pkg::LC_FB_MODE];
        fb_ok <= reg_wdata[io_failsafe_pkg::LC_FB_OK];
        missing <= reg_wdata[io_failsafe_pkg::LC_MISSING];
        critical <= reg_wdata[io_failsafe_pkg::LC_CRITICAL];
      end else if (reg_addr == io_failsafe_pkg::REG_IRQ_ENABLE) begin
        irq_enable <= reg_wdata[io_failsafe_pkg::IRQ_W-1:0];
      end
    end
  end

  // Fail-safe outputs; the switches are read live every cycle, so a move applies at once.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      analog_out_code <= io_failsafe_pkg::RESET_WORD;
      relay_out_first <= 1'b0;
      relay_out_second <= 1'b0;
    end else if (comm_err) begin
      if (!sw_s[io_failsafe_pkg::SW_AOUT_HOLD]) begin
        analog_out_code <= io_failsafe_pkg::RESET_WORD;
      end
      if (!sw_s[io_failsafe_pkg::SW_RELAY1_HOLD]) begin
        relay_out_first <= 1'b0;
      end
      if (!sw_s[io_failsafe_pkg::SW_RELAY2_HOLD]) begin
        relay_out_second <= 1'b0;
      end
    end else begin
      analog_out_code <= out_analog;
      relay_out_first <= out_relay[0];
      relay_out_second <= out_relay[1];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      range_4_20 <= 1'b0;
      digital_in_indicator <= 2'h0;
      relay_out_indicator <= 2'h0;
      supply_indicator <= 1'b0;
    end else begin
      range_4_20 <= sw_s[io_failsafe_pkg::SW_AIN_RANGE];
      digital_in_indicator <= din_s;
      relay_out_indicator <= {relay_out_second, relay_out_first};
      supply_indicator <= 1'b1;
    end
  end

  // Address change watch. The wheel needs two edges through its synchroniser and one more
  // into the compare register, so comparing waits until both hold the pin value; otherwise
  // any wheel setting other than 00 would look like a change right after reset.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      addr_prev <= 8'h00;
      prime_sr <= 2'h0;
      addr_primed <= 1'b0;
      addr_changed <= 1'b0;
    end else begin
      addr_prev <= {tens_s, units_s};
      prime_sr <= {prime_sr[0], 1'b1};
      addr_primed <= prime_sr[1];
      if (addr_primed && (addr_prev != {tens_s, units_s})) begin
        addr_changed <= 1'b1;
      end else if (reg_wr && reg_addr == io_failsafe_pkg::REG_LINK_CTRL
          && reg_wdata[io_failsafe_pkg::LC_ADDR_ACK]) begin
        addr_changed <= 1'b0;
      end
    end
  end

  // Flash generators run free, so an indicator may start a flash mid-phase, not on a phase edge.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      slow_cnt <= 32'h0;
      fast_cnt <= 32'h0;
      slow_ph <= 1'b0;
      fast_ph <= 1'b0;
    end else begin
      if (slow_cnt >= 32'(SLOW_HALF - 1)) begin
        slow_cnt <= 32'h0;
        slow_ph <= !slow_ph;
      end else begin
        slow_cnt <= slow_cnt + 32'h1;
      end
      if (fast_cnt >= 32'(FAST_HALF - 1)) begin
        fast_cnt <= 32'h0;
        fast_ph <= !fast_ph;
      end else begin
        fast_cnt <= fast_cnt + 32'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bus_activity_indicator <= 1'b0;
      error_indicator <= 1'b0;
    end else begin
      case (link_state)
        io_failsafe_pkg::LINK_CYCLIC: bus_activity_indicator <= 1'b1;
        io_failsafe_pkg::LINK_CONFIG: bus_activity_indicator <= fast_ph;
        default: bus_activity_indicator <= 1'b0;
      endcase
      if (critical) begin
        error_indicator <= 1'b1;
      end else if (missing || comm_err) begin
        error_indicator <= fast_ph;
      end else if (addr_changed) begin
        error_indicator <= slow_ph;
      end else begin
        error_indicator <= 1'b0;
      end
    end
  end

  // Interrupts: a set in the same cycle as a clear wins.
  always_comb begin
    events = 4'h0;
    events[io_failsafe_pkg::IRQ_COMM_ERR] = comm_err && !comm_err_d;
    events[io_failsafe_pkg::IRQ_ADDR_CHG] = addr_primed && (addr_prev != {tens_s, units_s});
    events[io_failsafe_pkg::IRQ_CRITICAL] = critical && !critical_d;
    events[io_failsafe_pkg::IRQ_INPUT_CHG] = addr_primed && (din_prev != din_s);
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_status <= io_failsafe_pkg::RESET_IRQ;
      comm_err_d <= 1'b0;
      critical_d <= 1'b0;
      din_prev <= 2'h0;
    end else begin
      comm_err_d <= comm_err;
      critical_d <= critical;
      din_prev <= din_s;
      if (reg_wr && reg_addr == io_failsafe_pkg::REG_IRQ_CLEAR) begin
        irq_status <= (irq_status & ~reg_wdata[io_failsafe_pkg::IRQ_W-1:0]) | events;
      end else begin
        irq_status <= irq_status | events;
      end
    end
  end

  assign irq = |(irq_status & irq_enable);

  // Register reads; data stand one cycle after the strobe, zero otherwise.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= io_failsafe_pkg::RESET_WORD;
    end else if (!reg_rd) begin
      reg_rdata <= io_failsafe_pkg::RESET_WORD;
    end else if (reg_addr == io_failsafe_pkg::REG_IN_ANALOG) begin
      reg_rdata <= analog_in_code;
    end else if (reg_addr == io_failsafe_pkg::REG_IN_DIGITAL) begin
      reg_rdata <= {14'h0, din_s};
    end else if (reg_addr == io_failsafe_pkg::REG_IN_STATUS) begin
      reg_rdata <= {tens_s, units_s, 1'b0, comm_err, addr_changed, addr_valid, 2'h0,
        sw_s[io_failsafe_pkg::SW_AIN_RANGE], 1'b0};
    end else if (reg_addr == io_failsafe_pkg::REG_OUT_ANALOG) begin
      reg_rdata <= out_analog;
    end else if (reg_addr == io_failsafe_pkg::REG_OUT_RELAY) begin
      reg_rdata <= out_relay;
    end else if (reg_addr == io_failsafe_pkg::REG_OUT_SPARE) begin
      reg_rdata <= out_spare;
    end else if (reg_addr == io_failsafe_pkg::REG_LINK_CTRL) begin
      reg_rdata <= {10'h0, critical, missing, fb_ok, fb_mode, link_state};
    end else if (reg_addr == io_failsafe_pkg::REG_IRQ_STATUS) begin
      reg_rdata <= {12'h0, irq_status};
    end else if (reg_addr == io_failsafe_pkg::REG_IRQ_ENABLE) begin
      reg_rdata <= {12'h0, irq_enable};
    end else begin
      reg_rdata <= io_failsafe_pkg::RESET_WORD;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  aout_reset_a: assert property ((comm_err && !sw_s[io_failsafe_pkg::SW_AOUT_HOLD]) |=>
    analog_out_code == io_failsafe_pkg::RESET_WORD)
    else $error("analog output not zeroed on comm error");
  aout_hold_a: assert property ((comm_err && sw_s[io_failsafe_pkg::SW_AOUT_HOLD]) |=>
    $stable(analog_out_code))
    else $error("analog output moved while held");
  relay_reset_a: assert property ((comm_err && !sw_s[io_failsafe_pkg::SW_RELAY1_HOLD]) |=>
    !relay_out_first)
    else $error("relay one not dropped on comm error");
  relay_hold_a: assert property ((comm_err && sw_s[io_failsafe_pkg::SW_RELAY2_HOLD]) |=>
    $stable(relay_out_second))
    else $error("relay two moved while held");
  fb_loss_a: assert property ((fb_mode && !fb_ok && !sw_s[io_failsafe_pkg::SW_AOUT_HOLD])
    |=> analog_out_code == io_failsafe_pkg::RESET_WORD)
    else $error("analog output not made safe on fieldbus loss");
  switch_live_a: assert property ($changed(front_switch[0]) ##2 $stable(front_switch[0])
    |=> range_4_20 == front_switch[0])
    else $error("switch change not applied");
  bus_led_a: assert property ((link_state == io_failsafe_pkg::LINK_CYCLIC) |=>
    bus_activity_indicator)
    else $error("bus indicator not steady in cyclic exchange");
  bus_off_a: assert property ((link_state == io_failsafe_pkg::LINK_NONE) |=>
    !bus_activity_indicator)
    else $error("bus indicator lit without link");
  err_steady_a: assert property (critical |=> error_indicator)
    else $error("error indicator not lit on critical error");
  err_off_a: assert property ((!critical && !missing && !comm_err && !addr_changed)
    |=> !error_indicator)
    else $error("error indicator lit without error");
  err_fast_a: assert property ((!critical && (missing || comm_err)) |=>
    error_indicator == $past(fast_ph))
    else $error("error indicator not on fast flash");
  err_slow_a: assert property ((!critical && !missing && !comm_err && addr_changed)
    |=> error_indicator == $past(slow_ph))
    else $error("error indicator not on slow flash");
  din_led_a: assert property (1'b1 |=> digital_in_indicator == $past(din_s))
    else $error("input indicator does not follow input");
  addr_bad_a: assert property ((tens_s != 4'h0 && units_s == 4'h0) |-> !addr_valid)
    else $error("tens with zero units accepted");
  img_read_a: assert property ((reg_rd && reg_addr == io_failsafe_pkg::REG_IN_ANALOG) |=>
    reg_rdata == $past(analog_in_code))
    else $error("analog input word read wrong");

  comm_loss_c: cover property (!comm_err ##1 comm_err);
  addr_chg_c: cover property (!addr_changed ##1 addr_changed);
  irq_fire_c: cover property (!irq ##1 irq);
  cyclic_c: cover property (link_state == io_failsafe_pkg::LINK_CONFIG ##1
    link_state == io_failsafe_pkg::LINK_CYCLIC);

endmodule : io_failsafe_status

// ===== bench/head_model.sv
// Register-bus master that stands in for the head module on the backplane.
// Assumes a slave that takes every strobe at once and answers a read in the next cycle.
`timescale 1ns/1ps
module head_model (
  input wire logic clk,
  output logic [3:0] reg_addr,
  output logic [15:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [15:0] reg_rdata
);
  // Only one extension module of the up to 32 on the rail is served here.
  initial begin
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  task automatic write_word(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    // Idle data is inverted so that a design sampling it late sees garbage, not the last word.
    reg_wdata <= ~d;
  endtask : write_word

  task automatic read_word(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata;
  endtask : read_word
endmodule : head_model

// ===== bench/io_failsafe_status_tb.sv
// Self-checking bench for the I/O module control block, with short flash parameters.
// Assumes the head model drives the register port; the bench drives all pins.
`timescale 1ns/1ps
module io_failsafe_status_tb;
  localparam logic [11:0] FS_TAB = {4'h0, 4'ha, 4'h6};
  localparam logic [44:0] AD_TAB = {9'h003, 9'h133, 9'h085, 9'h000, 9'h020};
  logic clk, rst_b, reg_wr, reg_rd, irq, range_4_20, supply_indicator;
  logic bus_activity_indicator, error_indicator, digital_in_first, digital_in_second;
  logic relay_out_first, relay_out_second;
  logic [3:0] reg_addr, front_switch, addr_tens, addr_units, sw;
  logic [15:0] reg_wdata, reg_rdata, analog_in_code, analog_out_code, d;
  logic [1:0] digital_in_indicator, relay_out_indicator;
  logic [8:0] ent;
  int num_errors = 0;
  int n_checks = 0;
  int cycles = 0;
  int n;

  head_model i_head (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  io_failsafe_status #(.SLOW_HALF(8), .FAST_HALF(4)) i_dut (.clk(clk), .rst_b(rst_b),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq), .front_switch(front_switch), .addr_tens(addr_tens),
    .addr_units(addr_units), .digital_in_first(digital_in_first),
    .digital_in_second(digital_in_second), .analog_in_code(analog_in_code),
    .analog_out_code(analog_out_code), .relay_out_first(relay_out_first),
    .relay_out_second(relay_out_second), .range_4_20(range_4_20),
    .supply_indicator(supply_indicator), .bus_activity_indicator(bus_activity_indicator),
    .error_indicator(error_indicator), .digital_in_indicator(digital_in_indicator),
    .relay_out_indicator(relay_out_indicator));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_word

  task automatic check_bit(input logic got, input logic exp);
    check_word({15'h0, got}, {15'h0, exp});
  endtask : check_bit

  task automatic check_range(input int got, input int lo, input int hi);
    n_checks++;
    if (got < lo || got > hi) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h to %h", $time, got, lo, hi);
    end
  endtask : check_range

  task automatic final_report;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : final_report

  task automatic wait_cyc(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask : wait_cyc

  // Counts level changes of one indicator over 64 cycles; sel 1 picks the bus indicator.
  task automatic toggles(input bit sel, output int t);
    logic prev;
    logic cur;
    t = 0;
    prev = sel ? bus_activity_indicator : error_indicator;
    repeat (64) begin
      wait_cyc(1);
      cur = sel ? bus_activity_indicator : error_indicator;
      if (cur !== prev) t++;
      prev = cur;
    end
  endtask : toggles

  task automatic set_link(input logic [15:0] v);
    i_head.write_word(io_failsafe_pkg::REG_LINK_CTRL, v);
    wait_cyc(4);
  endtask : set_link

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      num_errors++;
      final_report();
    end
  end

  initial begin
    rst_b = 1'b0;
    front_switch = 4'h0;
    addr_tens = 4'h0;
    addr_units = 4'h1;
    digital_in_first = 1'b0;
    digital_in_second = 1'b0;
    analog_in_code = 16'hbeef;
    wait_cyc(5);
    check_bit(supply_indicator, 1'b0);
    rst_b <= 1'b1;
    wait_cyc(4);
    check_bit(supply_indicator, 1'b1);
    check_bit(bus_activity_indicator, 1'b0);
    check_word(analog_out_code, 16'h0000);
    set_link(16'h0043);
    toggles(1'b1, n);
    check_range(n, 0, 0);
    check_bit(bus_activity_indicator, 1'b1);
    i_head.write_word(io_failsafe_pkg::REG_OUT_ANALOG, 16'h1234);
    i_head.write_word(io_failsafe_pkg::REG_OUT_RELAY, 16'h0003);
    wait_cyc(3);
    check_word(analog_out_code, 16'h1234);
    check_word({14'h0, relay_out_second, relay_out_first}, 16'h0003);
    check_word({14'h0, relay_out_indicator}, 16'h0003);
    i_head.read_word(io_failsafe_pkg::REG_OUT_ANALOG, d);
    check_word(d, 16'h1234);
    i_head.write_word(io_failsafe_pkg::REG_IN_ANALOG, 16'h0000);
    i_head.read_word(io_failsafe_pkg::REG_IN_ANALOG, d);
    check_word(d, 16'hbeef);
    i_head.read_word(4'hf, d);
    check_word(d, 16'h0000);
    digital_in_second <= 1'b1;
    wait_cyc(5);
    check_word({14'h0, digital_in_indicator}, 16'h0002);
    i_head.read_word(io_failsafe_pkg::REG_IN_DIGITAL, d);
    check_word(d, 16'h0002);
    for (int i = 0; i < 3; i++) begin
      sw = FS_TAB[i*4 +: 4];
      front_switch <= sw;
      set_link(16'h0000);
      check_word(analog_out_code, sw[1] ? 16'h1234 : 16'h0000);
      check_bit(relay_out_first, sw[2]);
      check_bit(relay_out_second, sw[3]);
      check_word({14'h0, relay_out_indicator}, {14'h0, sw[3], sw[2]});
      front_switch <= 4'h0;
      wait_cyc(5);
      check_word(analog_out_code, 16'h0000);
      check_bit(relay_out_first, 1'b0);
      set_link(16'h0003);
      check_word(analog_out_code, 16'h1234);
    end
    set_link(16'h0007);
    check_word(analog_out_code, 16'h0000);
    check_word({14'h0, relay_out_second, relay_out_first}, 16'h0000);
    toggles(1'b0, n);
    check_range(n, 15, 17);
    set_link(16'h000f);
    check_word(analog_out_code, 16'h1234);
    set_link(16'h0001);
    toggles(1'b1, n);
    check_range(n, 15, 17);
    set_link(16'h0013);
    toggles(1'b0, n);
    check_range(n, 15, 17);
    set_link(16'h0033);
    toggles(1'b0, n);
    check_range(n, 0, 0);
    check_bit(error_indicator, 1'b1);
    set_link(16'h0043);
    // Comm loss, critical error and input change have all occurred; the wheel has not moved.
    i_head.read_word(io_failsafe_pkg::REG_IRQ_STATUS, d);
    check_word(d, 16'h000d);
    i_head.write_word(io_failsafe_pkg::REG_IRQ_CLEAR, 16'h000f);
    for (int i = 0; i < 5; i++) begin
      ent = AD_TAB[i*9 +: 9];
      addr_tens <= ent[8:5];
      addr_units <= ent[4:1];
      wait_cyc(5);
      i_head.read_word(io_failsafe_pkg::REG_IN_STATUS, d);
      check_word({d[15:8], 7'h0, d[4]}, {ent[8:1], 7'h0, ent[0]});
      check_bit(d[5], 1'b1);
    end
    toggles(1'b0, n);
    check_range(n, 7, 9);
    i_head.write_word(io_failsafe_pkg::REG_IRQ_ENABLE, 16'h0000);
    wait_cyc(1);
    check_bit(irq, 1'b0);
    i_head.read_word(io_failsafe_pkg::REG_IRQ_STATUS, d);
    check_word(d, 16'h0002);
    i_head.write_word(io_failsafe_pkg::REG_IRQ_ENABLE, 16'h0002);
    wait_cyc(1);
    check_bit(irq, 1'b1);
    i_head.write_word(io_failsafe_pkg::REG_IRQ_CLEAR, 16'h0002);
    wait_cyc(1);
    check_bit(irq, 1'b0);
    set_link(16'h0043);
    toggles(1'b0, n);
    check_range(n, 0, 0);
    check_bit(error_indicator, 1'b0);
    front_switch <= 4'h1;
    wait_cyc(5);
    check_bit(range_4_20, 1'b1);
    i_head.read_word(io_failsafe_pkg::REG_IN_STATUS, d);
    check_bit(d[1], 1'b1);
    final_report();
  end
endmodule : io_failsafe_status_tb
